/* hdl/ssb_sequencer.sv */
/*
 * Start, stop and braking sequencer of a V/F motor drive with its
 * register file and output voltage scaling.
 * Assumes run_cmd comes from a pin, while the measured input voltage and
 * DC bus voltage arrive from converters on core_clk. Register access is
 * through a plain strobe port, read data valid one cycle after the read.
 */
`timescale 1ns/1ns

module ssb_sequencer #(
	parameter int unsigned TICK_CYCLES = ssb_pkg::TICK_CYCLES_DEF
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Commands and measurements
	input wire logic run_cmd,
	input wire logic [9:0] input_volt,
	input wire logic [9:0] dc_bus_volt,
	// Drive outputs
	output logic out_enable,
	output logic [15:0] out_freq,
	output logic [9:0] out_volt,
	output logic dc_inject,
	output logic [7:0] dc_current,
	output logic flux_brake_active,
	output logic power_brake_active,
	output logic stall_prev_active,
	output logic dwell_active,
	output ssb_pkg::ssb_state_e seq_state
);
	import ssb_pkg::*;

	// Move cur toward goal by at most step
	function automatic logic [15:0] step_toward(input logic [15:0] cur, input logic [15:0] goal,
			input logic [15:0] step);
		logic [15:0] gap;
		gap = (cur > goal) ? cur - goal : goal - cur;
		if (gap <= step) begin
			step_toward = goal;
		end else if (cur > goal) begin
			step_toward = cur - step;
		end else begin
			step_toward = cur + step;
		end
	endfunction

	// Reset release through two flops
	logic rst_meta_q, rst_n_q;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// Run pin synchroniser
	logic run_meta_q, run_q;
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			run_meta_q <= 1'b0;
			run_q <= 1'b0;
		end else begin
			run_meta_q <= run_cmd;
			run_q <= run_meta_q;
		end
	end

	// Register file
	logic start_mode_q, start_mode_d;
	logic [2:0] stop_mode_q, stop_mode_d;
	logic [3:0] stall_en_q, stall_en_d;
	logic [9:0] rated_q, rated_d, dclim_q, dclim_d;
	logic [15:0] base_q, base_d, target_q, target_d, step_q, step_d;
	logic [15:0] st_time_q, st_time_d, blank_q, blank_d, bk_time_q, bk_time_d;
	logic [15:0] bk_freq_q, bk_freq_d, dw_freq_q, dw_freq_d, dw_time_q, dw_time_d;
	logic [7:0] st_cur_q, st_cur_d, bk_cur_q, bk_cur_d;
	logic [31:0] rdata_q, rdata_d;
	ssb_state_e state_q, state_d;
	logic [15:0] freq_q, freq_d;
	logic [9:0] volt_q, volt_d;

	// Decode writes and build the read answer; unmapped reads return zero
	always_comb begin
		start_mode_d = start_mode_q;
		stop_mode_d = stop_mode_q;
		stall_en_d = stall_en_q;
		rated_d = rated_q;
		dclim_d = dclim_q;
		base_d = base_q;
		target_d = target_q;
		step_d = step_q;
		st_time_d = st_time_q;
		st_cur_d = st_cur_q;
		blank_d = blank_q;
		bk_time_d = bk_time_q;
		bk_cur_d = bk_cur_q;
		bk_freq_d = bk_freq_q;
		dw_freq_d = dw_freq_q;
		dw_time_d = dw_time_q;
		rdata_d = 32'h0000_0000;
		if (reg_wr) begin
			case (reg_addr)
				OFS_CTRL: begin
					start_mode_d = reg_wdata[CTRL_START_BIT];
					stop_mode_d = reg_wdata[CTRL_STOP_LSB +: 3];
					stall_en_d = reg_wdata[CTRL_STALL_LSB +: 4];
				end
				OFS_RATED_VOLT: rated_d = reg_wdata[9:0];
				OFS_BASE_FREQ: base_d = reg_wdata[15:0];
				OFS_TARGET_FREQ: target_d = reg_wdata[15:0];
				OFS_RAMP_STEP: step_d = reg_wdata[15:0];
				OFS_START_TIME: st_time_d = reg_wdata[15:0];
				OFS_START_CUR: st_cur_d = reg_wdata[7:0];
				OFS_BLANK_TIME: blank_d = reg_wdata[15:0];
				OFS_BRAKE_TIME: bk_time_d = reg_wdata[15:0];
				OFS_BRAKE_CUR: bk_cur_d = reg_wdata[7:0];
				OFS_BRAKE_FREQ: bk_freq_d = reg_wdata[15:0];
				OFS_DWELL_FREQ: dw_freq_d = reg_wdata[15:0];
				OFS_DWELL_TIME: dw_time_d = reg_wdata[15:0];
				OFS_DCBUS_LIMIT: dclim_d = reg_wdata[9:0];
				default: ;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				OFS_CTRL: rdata_d = {20'h0_0000, stall_en_q, 1'b0, stop_mode_q, 3'h0, start_mode_q};
				OFS_RATED_VOLT: rdata_d = {22'h00_0000, rated_q};
				OFS_BASE_FREQ: rdata_d = {16'h0000, base_q};
				OFS_TARGET_FREQ: rdata_d = {16'h0000, target_q};
				OFS_RAMP_STEP: rdata_d = {16'h0000, step_q};
				OFS_START_TIME: rdata_d = {16'h0000, st_time_q};
				OFS_START_CUR: rdata_d = {24'h00_0000, st_cur_q};
				OFS_BLANK_TIME: rdata_d = {16'h0000, blank_q};
				OFS_BRAKE_TIME: rdata_d = {16'h0000, bk_time_q};
				OFS_BRAKE_CUR: rdata_d = {24'h00_0000, bk_cur_q};
				OFS_BRAKE_FREQ: rdata_d = {16'h0000, bk_freq_q};
				OFS_DWELL_FREQ: rdata_d = {16'h0000, dw_freq_q};
				OFS_DWELL_TIME: rdata_d = {16'h0000, dw_time_q};
				OFS_DCBUS_LIMIT: rdata_d = {22'h00_0000, dclim_q};
				OFS_STATUS: rdata_d = {20'h0_0000, dwell_active, stall_prev_active,
					power_brake_active, flux_brake_active, dc_inject, out_enable, run_q,
					2'h0, state_q};
				OFS_OUT_FREQ: rdata_d = {16'h0000, freq_q};
				OFS_OUT_VOLT: rdata_d = {22'h00_0000, volt_q};
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// Register file storage
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			start_mode_q <= START_RAMP;
			stop_mode_q <= STOP_RAMP;
			stall_en_q <= 4'h0;
			rated_q <= RST_RATED_VOLT;
			dclim_q <= RST_DCBUS_LIMIT;
			base_q <= RST_BASE_FREQ;
			target_q <= RST_TARGET_FREQ;
			step_q <= RST_RAMP_STEP;
			st_time_q <= RST_START_TIME;
			st_cur_q <= RST_START_CUR;
			blank_q <= RST_BLANK_TIME;
			bk_time_q <= RST_BRAKE_TIME;
			bk_cur_q <= RST_BRAKE_CUR;
			bk_freq_q <= RST_BRAKE_FREQ;
			dw_freq_q <= RST_DWELL_FREQ;
			dw_time_q <= RST_DWELL_TIME;
			rdata_q <= 32'h0000_0000;
		end else begin
			start_mode_q <= start_mode_d;
			stop_mode_q <= stop_mode_d;
			stall_en_q <= stall_en_d;
			rated_q <= rated_d;
			dclim_q <= dclim_d;
			base_q <= base_d;
			target_q <= target_d;
			step_q <= step_d;
			st_time_q <= st_time_d;
			st_cur_q <= st_cur_d;
			blank_q <= blank_d;
			bk_time_q <= bk_time_d;
			bk_cur_q <= bk_cur_d;
			bk_freq_q <= bk_freq_d;
			dw_freq_q <= dw_freq_d;
			dw_time_q <= dw_time_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	// 10 ms time base shared by ramps and all duration counts
	logic [31:0] tick_cnt_q, tick_cnt_d;
	logic tick;
	assign tick = (tick_cnt_q == TICK_CYCLES - 1);
	always_comb begin
		tick_cnt_d = tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
	end
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			tick_cnt_q <= 32'h0000_0000;
		end else begin
			tick_cnt_q <= tick_cnt_d;
		end
	end

	// Sequencer: state, output frequency, duration timer, dwell tracking
	logic [15:0] timer_q, timer_d;
	logic dwell_done_q, dwell_done_d;
	logic dwell_skip, bus_high, dwell_hold;
	assign dwell_skip = (stop_mode_q == STOP_INJECT) && (dw_freq_q < bk_freq_q);
	assign bus_high = (stop_mode_q == STOP_POWER) && (dc_bus_volt > dclim_q);
	assign dwell_hold = (dw_time_q != 16'h0000) && !dwell_done_q && !dwell_skip &&
		(freq_q <= dw_freq_q) && (freq_q != 16'h0000);

	always_comb begin
		state_d = state_q;
		freq_d = freq_q;
		timer_d = (tick && timer_q != 16'hFFFF) ? timer_q + 16'h0001 : timer_q;
		dwell_done_d = dwell_done_q;
		case (state_q)
			SSB_IDLE: begin
				freq_d = 16'h0000;
				timer_d = 16'h0000;
				dwell_done_d = 1'b0;
				if (run_q) begin
					// Start method only matters when leaving idle
					state_d = (start_mode_q == START_INJECT) ? SSB_START_INJ : SSB_RUN;
				end
			end
			SSB_START_INJ: begin
				if (!run_q) begin
					state_d = SSB_IDLE;
				end else if (timer_q >= st_time_q) begin
					state_d = SSB_RUN;
				end
			end
			SSB_RUN: begin
				if (tick) begin
					freq_d = step_toward(freq_q, target_q, step_q);
				end
				if (!run_q) begin
					timer_d = 16'h0000;
					dwell_done_d = 1'b0;
					if (stop_mode_q == STOP_COAST) begin
						// Output drops at once; the motor spins down on its own
						state_d = SSB_IDLE;
						freq_d = 16'h0000;
					end else begin
						state_d = SSB_DECEL;
						freq_d = freq_q;
					end
				end
			end
			SSB_DECEL: begin
				if (run_q) begin
					state_d = SSB_RUN;
				end else if (stop_mode_q == STOP_INJECT && freq_q <= bk_freq_q) begin
					state_d = SSB_BLANK;
					freq_d = 16'h0000;
					timer_d = 16'h0000;
				end else if (freq_q == 16'h0000) begin
					state_d = SSB_IDLE;
				end else if (dwell_hold) begin
					freq_d = freq_q;
					if (timer_q >= dw_time_q) begin
						dwell_done_d = 1'b1;
					end
				end else if (tick && !bus_high) begin
					// In power braking, bus over the limit flattens the slope to zero
					freq_d = step_toward(freq_q, 16'h0000, step_q);
					timer_d = 16'h0000;
				end else begin
					timer_d = 16'h0000;
				end
			end
			SSB_BLANK: begin
				if (timer_q >= blank_q) begin
					state_d = SSB_BRAKE;
					timer_d = 16'h0000;
				end
			end
			SSB_BRAKE: begin
				if (timer_q >= bk_time_q) begin
					state_d = SSB_IDLE;
				end
			end
			default: begin
				state_d = SSB_IDLE;
				freq_d = 16'h0000;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= SSB_IDLE;
			freq_q <= 16'h0000;
			timer_q <= 16'h0000;
			dwell_done_q <= 1'b0;
		end else begin
			state_q <= state_d;
			freq_q <= freq_d;
			timer_q <= timer_d;
			dwell_done_q <= dwell_done_d;
		end
	end

	// Output voltage: linear to base, then capped by the supply
	logic [9:0] vin_idle_q, vin_idle_d, rated_eff;
	logic [25:0] v_prod;
	assign rated_eff = (rated_q == 10'h000) ? vin_idle_q : rated_q;
	assign v_prod = rated_eff * freq_q;
	always_comb begin
		vin_idle_d = (state_q == SSB_IDLE) ? input_volt : vin_idle_q;
		if (state_q != SSB_RUN && state_q != SSB_DECEL) begin
			volt_d = 10'h000;
		end else if (freq_q >= base_q) begin
			volt_d = (input_volt < rated_eff) ? input_volt : rated_eff;
		end else begin
			// The divider is costly but runs only on a registered path
			volt_d = 10'(v_prod / base_q);
		end
	end
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			vin_idle_q <= 10'h000;
			volt_q <= 10'h000;
		end else begin
			vin_idle_q <= vin_idle_d;
			volt_q <= volt_d;
		end
	end

	// Drive outputs from state and settings
	logic decel_now;
	assign decel_now = (state_q == SSB_DECEL);
	assign seq_state = state_q;
	assign out_freq = freq_q;
	assign out_volt = volt_q;
	assign out_enable = (state_q == SSB_RUN) || decel_now || (state_q == SSB_START_INJ) ||
		(state_q == SSB_BRAKE);
	assign dc_inject = (state_q == SSB_START_INJ) || (state_q == SSB_BRAKE);
	assign dc_current = (state_q == SSB_START_INJ) ? st_cur_q :
		(state_q == SSB_BRAKE) ? bk_cur_q : 8'h00;
	assign flux_brake_active = decel_now && (stop_mode_q == STOP_FLUX);
	assign power_brake_active = decel_now && (stop_mode_q == STOP_POWER);
	// Flux and power braking take over from stall prevention while slowing down
	assign stall_prev_active = decel_now && stall_en_q[STALL_DECEL_BIT] &&
		!flux_brake_active && !power_brake_active;
	assign dwell_active = decel_now && dwell_hold && !run_q;

	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n_q);

	sequence s_decel_to_blank;
		decel_now && !run_q ##1 state_q == SSB_BLANK;
	endsequence
	sequence s_blank_to_brake;
		state_q == SSB_BLANK ##1 state_q == SSB_BRAKE;
	endsequence

	chk_rated_at_base: assert property (
		state_q == SSB_RUN && run_q && freq_q == base_q && rated_q != 10'h000 &&
		input_volt >= rated_q |=> volt_q == $past(rated_q))
		else $error("rated voltage not produced at base frequency");
	chk_supply_cap: assert property (
		state_q == SSB_RUN && run_q && freq_q >= base_q && input_volt < rated_eff
		|=> volt_q == $past(input_volt))
		else $error("low supply not passed to output");
	// The first edge after release still finds the capture flop held in reset
	chk_idle_capture: assert property (
		rst_n_q && state_q == SSB_IDLE ##1 state_q == SSB_IDLE |-> vin_idle_q == $past(input_volt))
		else $error("idle input voltage not captured");
	chk_start_plain: assert property (
		state_q == SSB_IDLE && run_q && start_mode_q == START_RAMP |=> state_q == SSB_RUN)
		else $error("ramp start did not go straight to run");
	chk_start_inject: assert property (
		state_q == SSB_IDLE && run_q && start_mode_q == START_INJECT
		|=> state_q == SSB_START_INJ && dc_inject && dc_current == st_cur_q)
		else $error("injection start missing");
	chk_threshold_blank: assert property (
		decel_now && !run_q && stop_mode_q == STOP_INJECT && freq_q <= bk_freq_q
		|=> state_q == SSB_BLANK && !out_enable)
		else $error("brake threshold did not blank output");
	chk_brake_order: assert property (
		$rose(state_q == SSB_BRAKE) |-> $past(state_q == SSB_BLANK))
		else $error("brake entered without blank interval");
	chk_blank_blocks_out: assert property (
		s_decel_to_blank |-> !out_enable && !dc_inject && freq_q == 16'h0000)
		else $error("output not blocked on entering blank");
	chk_brake_level: assert property (
		s_blank_to_brake |-> dc_inject && dc_current == bk_cur_q)
		else $error("brake current wrong");
	chk_brake_end: assert property (
		state_q == SSB_BRAKE && timer_q >= bk_time_q |=> state_q == SSB_IDLE)
		else $error("brake duration not honoured");
	chk_coast_block: assert property (
		state_q == SSB_RUN && !run_q && stop_mode_q == STOP_COAST
		|=> state_q == SSB_IDLE && !out_enable && freq_q == 16'h0000)
		else $error("coast stop did not block output");
	chk_flux_priority: assert property (
		flux_brake_active |-> decel_now && !stall_prev_active)
		else $error("flux braking lost priority");
	chk_power_hold: assert property (
		power_brake_active && bus_high && !run_q && tick && !dwell_hold && freq_q > bk_freq_q
		|=> freq_q == $past(freq_q) && !stall_prev_active)
		else $error("power braking did not hold frequency");
	chk_dwell_skip: assert property (
		dwell_skip |-> !dwell_active)
		else $error("dwell ran below brake threshold");
endmodule

/* hdl/ssb_pkg.sv */
/*
 * Shared constants for the start, stop and braking sequencer: register
 * offsets, field positions, reset values, timing constants and states.
 * Assumes a 25 MHz core clock; all durations count in 10 ms steps.
 */
package ssb_pkg;

	// Clock and time base
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned TIME_UNIT_NS = 10_000_000; // 0.01 s per duration step
	localparam int unsigned TICK_CYCLES_DEF = TIME_UNIT_NS / CLK_PERIOD_NS;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_RATED_VOLT = 8'h04;
	localparam logic [7:0] OFS_BASE_FREQ = 8'h08;
	localparam logic [7:0] OFS_TARGET_FREQ = 8'h0C;
	localparam logic [7:0] OFS_RAMP_STEP = 8'h10;
	localparam logic [7:0] OFS_START_TIME = 8'h14;
	localparam logic [7:0] OFS_START_CUR = 8'h18;
	localparam logic [7:0] OFS_BLANK_TIME = 8'h1C;
	localparam logic [7:0] OFS_BRAKE_TIME = 8'h20;
	localparam logic [7:0] OFS_BRAKE_CUR = 8'h24;
	localparam logic [7:0] OFS_BRAKE_FREQ = 8'h28;
	localparam logic [7:0] OFS_DWELL_FREQ = 8'h2C;
	localparam logic [7:0] OFS_DWELL_TIME = 8'h30;
	localparam logic [7:0] OFS_DCBUS_LIMIT = 8'h34;
	localparam logic [7:0] OFS_STATUS = 8'h38;
	localparam logic [7:0] OFS_OUT_FREQ = 8'h3C;
	localparam logic [7:0] OFS_OUT_VOLT = 8'h40;

	// Control register fields
	localparam int unsigned CTRL_START_BIT = 0;
	localparam int unsigned CTRL_STOP_LSB = 4;
	localparam int unsigned CTRL_STALL_LSB = 8;
	localparam int unsigned STALL_DECEL_BIT = 3;

	// Start and stop method codes
	localparam logic START_RAMP = 1'b0;
	localparam logic START_INJECT = 1'b1;
	localparam logic [2:0] STOP_RAMP = 3'h0;
	localparam logic [2:0] STOP_INJECT = 3'h1;
	localparam logic [2:0] STOP_COAST = 3'h2;
	localparam logic [2:0] STOP_FLUX = 3'h3;
	localparam logic [2:0] STOP_POWER = 3'h4;

	// Reset values (frequency in 0.01 Hz, time in 0.01 s, current in %)
	localparam logic [9:0] RST_RATED_VOLT = 10'h0DC; // 220 V
	localparam logic [15:0] RST_BASE_FREQ = 16'h1770; // 60.00 Hz
	localparam logic [15:0] RST_TARGET_FREQ = 16'h0000;
	localparam logic [15:0] RST_RAMP_STEP = 16'h0001;
	localparam logic [15:0] RST_START_TIME = 16'h0000; // 0.00 s
	localparam logic [7:0] RST_START_CUR = 8'h32; // 50 %
	localparam logic [15:0] RST_BLANK_TIME = 16'h000A; // 0.10 s
	localparam logic [15:0] RST_BRAKE_TIME = 16'h0064; // 1.00 s
	localparam logic [7:0] RST_BRAKE_CUR = 8'h32; // 50 %
	localparam logic [15:0] RST_BRAKE_FREQ = 16'h01F4; // 5.00 Hz
	localparam logic [15:0] RST_DWELL_FREQ = 16'h0000;
	localparam logic [15:0] RST_DWELL_TIME = 16'h0000;
	localparam logic [9:0] RST_DCBUS_LIMIT = 10'h3FF;

	// Sequencer states, Gray coded along idle-start-run-decel-blank-brake
	typedef enum logic [2:0] {
		SSB_IDLE = 3'b000,
		SSB_START_INJ = 3'b001,
		SSB_RUN = 3'b011,
		SSB_DECEL = 3'b010,
		SSB_BLANK = 3'b110,
		SSB_BRAKE = 3'b111
	} ssb_state_e;

endpackage

/* verification/ssb_motor_model.sv */
/*
 * Behavioural motor and power stage seen from the sequencer outputs.
 * Assumes the bench commands regeneration; the bus level is the only feedback.
 */
`timescale 1ns/1ns

module ssb_motor_model (
	// Clock
	input wire logic core_clk,
	// Drive from the sequencer
	input wire logic out_enable,
	input wire logic [15:0] out_freq,
	// Bench command: load pushes energy back while spinning
	input wire logic regen_hi,
	// Feedback
	output logic [9:0] dc_bus_volt
);
	// Bus pumps up only while the stage conducts a spinning motor under regen
	always_ff @(posedge core_clk) begin
		if (regen_hi && out_enable && out_freq != 16'h0000)
			dc_bus_volt <= 10'h1F4;
		else
			dc_bus_volt <= 10'h12C;
	end
endmodule

/* verification/test_ssb_sequencer.sv */
/*
 * Self-checking bench for the start, stop and braking sequencer.
 * Assumes a short duration tick (4 cycles) so every timed phase is brief.
 */
`timescale 1ns/1ns

module test_ssb_sequencer;
	import ssb_pkg::*;
	localparam int TK = 4;
	logic core_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, run_cmd = 0, regen_hi = 0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
	logic [9:0] input_volt = 10'h12C, dc_bus_volt, out_volt;
	logic out_enable, dc_inject, flux_brake_active, power_brake_active;
	logic stall_prev_active, dwell_active;
	logic [15:0] out_freq;
	logic [7:0] dc_current;
	ssb_state_e seq_state;
	int error_cnt = 0, num_checks = 0, cycles = 0;

	ssb_sequencer #(.TICK_CYCLES(TK)) u_ssb_sequencer (.core_clk(core_clk), .nrst(nrst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .run_cmd(run_cmd), .input_volt(input_volt),
		.dc_bus_volt(dc_bus_volt), .out_enable(out_enable), .out_freq(out_freq),
		.out_volt(out_volt), .dc_inject(dc_inject), .dc_current(dc_current),
		.flux_brake_active(flux_brake_active), .power_brake_active(power_brake_active),
		.stall_prev_active(stall_prev_active), .dwell_active(dwell_active),
		.seq_state(seq_state));
	ssb_motor_model u_ssb_motor_model (.core_clk(core_clk), .out_enable(out_enable),
		.out_freq(out_freq), .regen_hi(regen_hi), .dc_bus_volt(dc_bus_volt));

	// 25 MHz clock and a hang guard sized well past the whole sequence
	always #20 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		if (error_cnt == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Sample one step after the edge so the design's updates have landed
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic wait_st(input ssb_state_e st, input int lim);
		int n;
		n = 0;
		while (seq_state !== st && n < lim) begin
			cyc(1);
			n++;
		end
		chk("seq_state", 32'(st), 32'(seq_state));
	endtask

	task automatic stay(input ssb_state_e st, output int n);
		n = 0;
		while (seq_state === st && n < 200) begin
			cyc(1);
			n++;
		end
	endtask

	// Run to 100 units of frequency; base is set to the same point
	task automatic spin_up(input logic [31:0] ctrl);
		int n;
		n = 0;
		wr(OFS_CTRL, ctrl);
		@(posedge core_clk) run_cmd <= 1'b1;
		wait_st(SSB_RUN, 40);
		while (out_freq !== 16'd100 && n < 100) begin
			cyc(1);
			n++;
		end
		chk("out_freq", 32'd100, 32'(out_freq));
	endtask

	task automatic stop_idle(input int lim);
		@(posedge core_clk) run_cmd <= 1'b0;
		wait_st(SSB_IDLE, lim);
	endtask

	task automatic t_regs();
		logic [7:0] ra [11] = '{OFS_CTRL, OFS_RATED_VOLT, OFS_BASE_FREQ, OFS_START_TIME,
			OFS_START_CUR, OFS_BLANK_TIME, OFS_BRAKE_TIME, OFS_BRAKE_CUR, OFS_BRAKE_FREQ,
			OFS_DCBUS_LIMIT, 8'h7C};
		logic [31:0] rv [11] = '{32'h0, 32'(RST_RATED_VOLT), 32'(RST_BASE_FREQ), 32'h0,
			32'd50, 32'd10, 32'd100, 32'd50, 32'd500, 32'h3FF, 32'h0};
		logic [31:0] d;
		for (int i = 0; i < 11; i++) begin
			rd(ra[i], d);
			chk("reset_value", rv[i], d);
		end
		wr(OFS_OUT_FREQ, 32'h0000_FFFF);
		rd(OFS_OUT_FREQ, d);
		chk("out_freq_ro", 32'h0, d);
	endtask

	// Plain start, voltage law at and below base, stop by ramp
	task automatic t_ramp();
		int n;
		logic [31:0] d;
		n = 0;
		wr(OFS_BASE_FREQ, 32'd100);
		wr(OFS_TARGET_FREQ, 32'd100);
		wr(OFS_RAMP_STEP, 32'd10);
		wr(OFS_CTRL, 32'h0);
		@(posedge core_clk) run_cmd <= 1'b1;
		wait_st(SSB_RUN, 5);
		while (out_freq !== 16'd50 && n < 60) begin
			cyc(1);
			n++;
		end
		cyc(2);
		chk("out_volt_half", 32'd110, 32'(out_volt));
		spin_up(32'h0);
		cyc(2);
		chk("out_volt_base", 32'd220, 32'(out_volt));
		rd(OFS_OUT_VOLT, d);
		chk("out_volt_reg", 32'd220, d);
		@(posedge core_clk) input_volt <= 10'd200;
		cyc(3);
		chk("out_volt_low_in", 32'd200, 32'(out_volt));
		wr(OFS_CTRL, 32'h1);
		cyc(TK * 2);
		chk("start_mode_late", 32'(SSB_RUN), 32'(seq_state));
		@(posedge core_clk) run_cmd <= 1'b0;
		wait_st(SSB_DECEL, 5);
		wait_st(SSB_IDLE, 80);
		chk("out_freq_stop", 32'h0, 32'(out_freq));
		@(posedge core_clk) input_volt <= 10'd250;
		wr(OFS_RATED_VOLT, 32'h0);
		wr(OFS_CTRL, 32'h0);
		@(posedge core_clk) run_cmd <= 1'b1;
		n = 0;
		while (out_freq !== 16'd50 && n < 60) begin
			cyc(1);
			n++;
		end
		cyc(2);
		chk("out_volt_idle_in", 32'd125, 32'(out_volt));
		stop_idle(80);
		wr(OFS_RATED_VOLT, 32'd220);
	endtask

	task automatic t_inject();
		int n;
		wr(OFS_START_TIME, 32'd2);
		wr(OFS_START_CUR, 32'd80);
		wr(OFS_CTRL, 32'h1);
		@(posedge core_clk) run_cmd <= 1'b1;
		wait_st(SSB_START_INJ, 5);
		chk("inj_flags", {1'b1, 1'b1, 8'd80, 16'd0}, {dc_inject, out_enable, dc_current, out_freq});
		stay(SSB_START_INJ, n);
		chk("inj_len_ok", 32'd1, 32'(n >= TK && n <= 3 * TK));
		chk("after_inj", 32'(SSB_RUN), 32'(seq_state));
		stop_idle(80);
	endtask

	// Brake stop with a dwell point below the brake threshold
	task automatic t_brake();
		int n;
		logic [15:0] f;
		logic dw;
		dw = 1'b0;
		wr(OFS_BRAKE_FREQ, 32'd50);
		wr(OFS_BLANK_TIME, 32'd2);
		wr(OFS_BRAKE_TIME, 32'd3);
		wr(OFS_BRAKE_CUR, 32'd70);
		wr(OFS_DWELL_FREQ, 32'd30);
		wr(OFS_DWELL_TIME, 32'd5);
		spin_up(32'h10);
		@(posedge core_clk) run_cmd <= 1'b0;
		wait_st(SSB_DECEL, 5);
		f = out_freq;
		while (seq_state === SSB_DECEL && f > 16'd0) begin
			f = out_freq;
			dw |= dwell_active;
			cyc(1);
		end
		chk("brk_at_thr", 32'd1, 32'(f <= 16'd50 && f > 16'd40));
		chk("no_dwell", 32'd0, 32'(dw));
		chk("blank_state", 32'(SSB_BLANK), 32'(seq_state));
		chk("blank_out", 32'h0, {out_enable, dc_inject});
		stay(SSB_BLANK, n);
		chk("blank_len_ok", 32'd1, 32'(n >= TK && n <= 3 * TK));
		chk("brake_state", 32'(SSB_BRAKE), 32'(seq_state));
		chk("brake_drive", {1'b1, 8'd70}, {dc_inject, dc_current});
		stay(SSB_BRAKE, n);
		chk("brake_len_ok", 32'd1, 32'(n >= 2 * TK && n <= 4 * TK));
		chk("brake_end", 32'(SSB_IDLE), 32'(seq_state));
	endtask

	task automatic t_stops();
		logic [15:0] f;
		logic [31:0] d;
		int n;
		spin_up(32'h20);
		stop_idle(4);
		chk("coast_out", 32'h0, {out_enable, out_freq});
		spin_up(32'h830);
		@(posedge core_clk) run_cmd <= 1'b0;
		wait_st(SSB_DECEL, 5);
		chk("flux_prio", 32'h2, {flux_brake_active, stall_prev_active});
		// Dwell is not skipped outside brake stop, so the hold must show up here
		n = 0;
		while (!dwell_active && seq_state === SSB_DECEL && n < 60) begin
			cyc(1);
			n++;
		end
		f = out_freq;
		chk("dwell_on", 32'd1, 32'(dwell_active && f <= 16'd30 && f != 16'd0));
		cyc(2 * TK);
		chk("dwell_hold", 32'(f), 32'(out_freq));
		wait_st(SSB_IDLE, 80);
		chk("flux_idle", 32'h0, 32'(flux_brake_active));
		spin_up(32'h800);
		chk("stall_run", 32'h0, 32'(stall_prev_active));
		@(posedge core_clk) run_cmd <= 1'b0;
		wait_st(SSB_DECEL, 5);
		chk("stall_dec", 32'h1, 32'(stall_prev_active));
		wait_st(SSB_IDLE, 80);
		wr(OFS_DCBUS_LIMIT, 32'd400);
		regen_hi <= 1'b1;
		spin_up(32'h840);
		@(posedge core_clk) run_cmd <= 1'b0;
		wait_st(SSB_DECEL, 5);
		cyc(3);
		chk("power_prio", 32'h2, {power_brake_active, stall_prev_active});
		rd(OFS_STATUS, d);
		chk("status_power", 32'h0000_0242, d);
		f = out_freq;
		cyc(3 * TK);
		chk("power_hold", 32'(f), 32'(out_freq));
		@(posedge core_clk) regen_hi <= 1'b0;
		wait_st(SSB_IDLE, 100);
	endtask

	initial begin
		cyc(12);
		@(posedge core_clk) nrst <= 1'b1;
		cyc(4);
		t_regs();
		t_ramp();
		t_inject();
		t_brake();
		t_stops();
		wrap_up();
	end
endmodule
